// >>> jsb_pkg.sv
package jsb_pkg;
    localparam logic [7:0] JSB_OFF_CTRL = 8'h0f;
    localparam logic [7:0] JSB_OFF_HPOS = 8'h10;
    localparam logic [7:0] JSB_OFF_VPOS = 8'h11;
    localparam logic [7:0] JSB_OFF_HPTH = 8'h12;
    localparam logic [7:0] JSB_OFF_HNTH = 8'h13;
    localparam logic [7:0] JSB_OFF_VPTH = 8'h14;
    localparam logic [7:0] JSB_OFF_VNTH = 8'h15;
    localparam logic [7:0] JSB_OFF_SCALE = 8'h2d;
    // Reset-done control value; bit 0 reflects live state
    localparam logic [7:0] JSB_CTRL_DONE = 8'hf0;
    localparam logic [7:0] JSB_CTRL_LOWPWR = 8'h00;
    localparam logic [7:0] JSB_RST_ZERO = 8'h00;
    localparam logic [7:0] JSB_SCALE_RST = 8'h00;
    localparam logic [6:0] JSB_ADDR_BASE = 7'h40;
    localparam int JSB_BIT_SOFTRST = 1;
    localparam int JSB_BIT_INTFN = 2;
    localparam int JSB_BIT_IDLE = 7;
    localparam int JSB_TB_LSB = 4;
    localparam int JSB_TB_MSB = 6;
    localparam int JSB_CLK_HZ = 50_000_000;
    localparam int JSB_BASE_MS = 20;
    localparam int JSB_BASE_CYC = JSB_CLK_HZ / 1000 * JSB_BASE_MS;
    localparam int JSB_CONV_US = 450;
    localparam int JSB_CONV_CYC = JSB_CLK_HZ / 1_000_000 * JSB_CONV_US;

    typedef struct packed {
        logic signed [7:0] x;
        logic signed [7:0] y;
    } jsb_coord_s;

    typedef enum logic [1:0] {JSB_ST_STARTUP, JSB_ST_MEASURE, JSB_ST_WAIT} jsb_state_e;
endpackage : jsb_pkg

// >>> jsb_sensor.sv
`timescale 1ns/10ps
// Contract
// - Power-on clears all registers except control (loaded with F0h) once only
// - After reset control reads F0h or F1h
// - X at 10h, Y at 11h; Y-read clears irq
// - Four independent threshold registers
// - Control bit 2 selects threshold interrupt
// - Bit 7 and bits 6:4 pace measurements
// - Slave address 40h or 41h by pin
module jsb_sensor #(
    parameter int BASE_CYC = jsb_pkg::JSB_BASE_CYC,
    parameter int CONV_CYC = jsb_pkg::JSB_CONV_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic external_reset_low,
    // Address strap
    input wire logic addr_sel,
    // Register port from the slave front end
    input wire logic [6:0] bus_dev_addr,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_reg,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic bus_ack,
    // Sampled position
    input jsb_pkg::jsb_coord_s sample,
    // Interrupt pin, open drain
    output logic motion_irq_low_o,
    output logic motion_irq_low_oe
);
    import jsb_pkg::*;

    ////////////////////////////////////////////////////////////////////
    jsb_state_e state;
    jsb_state_e next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] scale;
    logic [7:0] next_scale;
    logic signed [7:0] hpth;
    logic signed [7:0] next_hpth;
    logic signed [7:0] hnth;
    logic signed [7:0] next_hnth;
    logic signed [7:0] vpth;
    logic signed [7:0] next_vpth;
    logic signed [7:0] vnth;
    logic signed [7:0] next_vnth;
    jsb_coord_s pos;
    jsb_coord_s next_pos;
    logic irq;
    logic next_irq;
    // Cycle counter shared by conversion and wait
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [7:0] next_rdata;
    logic next_ack;
    logic hit;
    logic outside;
    logic ready;
    logic reload;

    // Strap: base address plus pin
    function automatic logic [6:0] slave_addr(input logic pin);
        return JSB_ADDR_BASE | {6'h00, pin};
    endfunction : slave_addr

    // Wait period: 20ms scaled by timebase field
    function automatic logic [31:0] period(input logic [7:0] c);
        return 32'(BASE_CYC) << c[JSB_TB_MSB:JSB_TB_LSB];
    endfunction : period

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        hit = (bus_dev_addr == slave_addr(addr_sel));
        // pin low or soft reset bit forces defaults
        reload = !external_reset_low || ctrl[JSB_BIT_SOFTRST];
        outside = (sample.x > hpth) || (sample.x < hnth) ||
                  (sample.y > vpth) || (sample.y < vnth);
        next_state = state;
        next_ctrl = ctrl;
        next_scale = scale;
        next_hpth = hpth;
        next_hnth = hnth;
        next_vpth = vpth;
        next_vnth = vnth;
        next_pos = pos;
        next_irq = irq;
        next_cnt = cnt;
        next_ack = 1'b0;
        next_rdata = bus_rdata;
        ready = 1'b0;
        unique case (state)
            JSB_ST_STARTUP: begin
                next_cnt = '0;
                next_state = JSB_ST_MEASURE;
            end
            JSB_ST_MEASURE: begin
                if (cnt >= 32'(CONV_CYC) - 32'd1) begin
                    ready = 1'b1;
                    next_pos = sample;
                    next_cnt = '0;
                    next_state = JSB_ST_WAIT;
                end else begin
                    next_cnt = cnt + 32'd1;
                end
            end
            JSB_ST_WAIT: begin
                // idle bit set holds off new samples
                // zero control gives base 20ms pacing
                // Counts up against the live timebase, so a control
                // write takes effect on the wait already running
                if (!ctrl[JSB_BIT_IDLE]) begin
                    if (cnt >= period(ctrl) - 32'd1) begin
                        next_cnt = '0;
                        next_state = JSB_ST_MEASURE;
                    end else begin
                        next_cnt = cnt + 32'd1;
                    end
                end
            end
        endcase
        if (ready) begin
            if (ctrl[JSB_BIT_INTFN]) begin
                next_irq = outside;
            end else begin
                next_irq = 1'b1;
            end
        end
        if (hit && bus_rd) begin
            next_ack = 1'b1;
            unique case (bus_reg)
                // reset-done value, bit 0 set while waiting
                JSB_OFF_CTRL: next_rdata = ctrl | {7'h00, state == JSB_ST_WAIT};
                JSB_OFF_HPOS: next_rdata = pos.x;
                JSB_OFF_VPOS: next_rdata = pos.y;
                JSB_OFF_HPTH: next_rdata = hpth;
                JSB_OFF_HNTH: next_rdata = hnth;
                JSB_OFF_VPTH: next_rdata = vpth;
                JSB_OFF_VNTH: next_rdata = vnth;
                JSB_OFF_SCALE: next_rdata = scale;
                default: next_rdata = JSB_RST_ZERO;
            endcase
            // Y read clears pending irq; new sample wins
            if (bus_reg == JSB_OFF_VPOS && !ready) begin
                next_irq = 1'b0;
            end
        end
        if (hit && bus_wr) begin
            next_ack = 1'b1;
            unique case (bus_reg)
                JSB_OFF_CTRL: next_ctrl = bus_wdata;
                JSB_OFF_HPTH: next_hpth = bus_wdata;
                JSB_OFF_HNTH: next_hnth = bus_wdata;
                JSB_OFF_VPTH: next_vpth = bus_wdata;
                JSB_OFF_VNTH: next_vnth = bus_wdata;
                JSB_OFF_SCALE: next_scale = bus_wdata;
                default: ;
            endcase
        end
        // pin low or soft reset reloads defaults every edge
        // Bus keeps answering, so a poll sees the default control
        // Read data is left alone, it stands until the next read
        if (reload) begin
            next_state = JSB_ST_STARTUP;
            next_ctrl = JSB_CTRL_DONE;
            next_scale = JSB_SCALE_RST;
            next_hpth = JSB_RST_ZERO;
            next_hnth = JSB_RST_ZERO;
            next_vpth = JSB_RST_ZERO;
            next_vnth = JSB_RST_ZERO;
            next_pos = '0;
            next_irq = 1'b0;
            next_cnt = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-on clears once; later resets go through reload
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= JSB_ST_STARTUP;
            ctrl <= JSB_CTRL_DONE;
            scale <= JSB_SCALE_RST;
            {hpth, hnth, vpth, vnth} <= {4{JSB_RST_ZERO}};
            pos <= '0;
            irq <= 1'b0;
            cnt <= '0;
            bus_rdata <= JSB_RST_ZERO;
            bus_ack <= 1'b0;
            motion_irq_low_o <= 1'b0;
            motion_irq_low_oe <= 1'b0;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
            scale <= next_scale;
            hpth <= next_hpth;
            hnth <= next_hnth;
            vpth <= next_vpth;
            vnth <= next_vnth;
            pos <= next_pos;
            irq <= next_irq;
            cnt <= next_cnt;
            bus_rdata <= next_rdata;
            bus_ack <= next_ack;
            motion_irq_low_o <= 1'b0;
            // Registered from next_irq, so the pin moves with irq
            motion_irq_low_oe <= next_irq;
        end
    end
endmodule : jsb_sensor

// >>> jsb_sensor_monitor.sv
`timescale 1ns/10ps
module jsb_sensor_monitor (
    // Clock, reset, strap
    input wire logic clk, arst_n, external_reset_low, addr_sel,
    // Register port and pin
    input wire logic bus_wr, bus_rd, bus_ack, motion_irq_low_o, motion_irq_low_oe,
    input wire logic [6:0] bus_dev_addr,
    input wire logic [7:0] bus_reg, bus_wdata, bus_rdata,
    input jsb_pkg::jsb_coord_s sample
);
    logic hit;
    assign hit = (bus_wr | bus_rd) && bus_dev_addr == {6'h20, addr_sel};
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_ack_taken:
        assert property (hit |=> bus_ack) else $error("missing ack");
    a_ack_foreign:
        assert property (!hit |=> !bus_ack) else $error("stray ack");
    a_rdata_held:
        assert property (!(hit && bus_rd) |=> $stable(bus_rdata)) else $error("rdata moved");
    a_unmapped_zero:
        assert property (hit && bus_rd && bus_reg == 8'h3f |=> bus_rdata == 8'h00)
        else $error("unmapped not zero");
    // Pin reset reloads each edge, so the read sees defaults
    a_ctrl_default:
        assert property (hit && bus_rd && bus_reg == 8'h0f && !external_reset_low
            && !$past(external_reset_low) |=> bus_rdata[7:1] == 7'h78) else $error("ctrl default");
    a_irq_release:
        assert property (hit && bus_rd && bus_reg == 8'h11 |=> !motion_irq_low_oe)
        else $error("irq kept");
    a_pin_reset:
        assert property (!external_reset_low [*3] |-> !motion_irq_low_oe) else $error("irq in reset");
    a_drive_low:
        assert property (motion_irq_low_o == 1'b0) else $error("pin driven high");
endmodule : jsb_sensor_monitor
bind jsb_sensor jsb_sensor_monitor u_mon (.*);

// >>> jsb_host.sv
`timescale 1ns/10ps
module jsb_host (
    // Clock and strap
    input wire logic clk, addr_sel,
    // Pin and register port
    output logic external_reset_low = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0,
    output logic [6:0] bus_dev_addr = 7'h00,
    output logic [7:0] bus_reg = 8'h00, bus_wdata = 8'h00
);
    task automatic pin(input logic v);
        @(posedge clk);
        external_reset_low <= v;
    endtask : pin
    task automatic op(input logic w, input logic [7:0] r, d, input logic miss);
        @(posedge clk);
        bus_dev_addr <= {6'h20, addr_sel ^ miss};
        bus_wr <= w;
        bus_rd <= !w;
        bus_reg <= r;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        // Stale data must not look valid
        bus_wdata <= ~d;
    endtask : op
endmodule : jsb_host

// >>> tb_joystick_sensor_bringup.sv
`timescale 1ns/10ps
module tb_joystick_sensor_bringup;
    import jsb_pkg::*;
    localparam int BC = 50;
    logic clk = 1'b0, arst_n = 1'b0, addr_sel = 1'b0;
    logic external_reset_low, bus_wr, bus_rd, bus_ack, motion_irq_low_o, motion_irq_low_oe;
    logic [6:0] bus_dev_addr;
    logic [7:0] bus_reg, bus_wdata, bus_rdata;
    logic [7:0] th [4];
    logic [15:0] q [$];
    logic [15:0] e;
    jsb_coord_s sample = '0;
    int n_fail = 0, compares = 0, cyc = 0, seed = 94552, sx = 0, sy = 0, i;
    logic signed [7:0] ox, oy;
    always #10 clk = ~clk;
    jsb_sensor #(.BASE_CYC(BC), .CONV_CYC(5)) uut (
        .clk(clk),
        .arst_n(arst_n),
        .external_reset_low(external_reset_low),
        .addr_sel(addr_sel),
        .bus_dev_addr(bus_dev_addr),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_reg(bus_reg),
        .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata),
        .bus_ack(bus_ack),
        .sample(sample),
        .motion_irq_low_o(motion_irq_low_o),
        .motion_irq_low_oe(motion_irq_low_oe)
    );
    jsb_host host (
        .clk(clk),
        .addr_sel(addr_sel),
        .external_reset_low(external_reset_low),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_dev_addr(bus_dev_addr),
        .bus_reg(bus_reg),
        .bus_wdata(bus_wdata)
    );
    task automatic stop_test;
        // Notes left over mean an answer never came
        if (q.size() != 0)
            bad("answer missing");
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic bad(input string m);
        n_fail++;
        $display("ERROR %0t %s", $time, m);
    endtask : bad
    // Note is {mask, value}; writes carry a zero mask
    task automatic acc(input logic w, input logic [7:0] r, d, input logic [15:0] x);
        q.push_back(x);
        host.op(w, r, d, 1'b0);
    endtask : acc
    task automatic irq_is(input logic v);
        // Look mid-cycle, after the launching edge has settled
        @(negedge clk);
        for (i = 0; i < 4 * BC && motion_irq_low_oe !== v; i++)
            @(negedge clk);
        compares++;
        if (motion_irq_low_oe !== v)
            bad("irq level");
        @(posedge clk);
    endtask : irq_is
    function automatic jsb_coord_s rnd();
        rnd.x = 8'($random(seed) % 20);
        rnd.y = 8'($random(seed) % 20);
    endfunction : rnd
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            bad("timeout");
            stop_test();
        end
        if (bus_ack === 1'b1 && q.size() == 0) begin
            bad("ack with no request");
        end else if (bus_ack === 1'b1) begin
            e = q.pop_front();
            compares++;
            if ((bus_rdata & e[15:8]) !== e[7:0])
                bad("read data");
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        host.pin(1'b0);
        acc(0, 8'h0f, 0, 16'hfef0);
        host.pin(1'b1);
        acc(0, 8'h0f, 0, 16'hfef0);
        acc(1, 8'h2d, 8'h06, 0);
        acc(0, 8'h2d, 0, 16'hff06);
        acc(0, 8'h3f, 0, 16'hff00);
        host.op(0, 8'h0f, 0, 1'b1);
        sample <= rnd();
        acc(1, 8'h0f, 8'h00, 0);
        acc(0, 8'h11, 0, 0);
        for (int k = 0; k < 16; k++) begin
            irq_is(1'b1);
            acc(0, 8'h10, 0, {8'hff, sample.x});
            acc(0, 8'h11, 0, {8'hff, sample.y});
            sx += $signed(sample.x);
            sy += $signed(sample.y);
            sample <= rnd();
        end
        ox = 8'(-(sx >>> 4));
        oy = 8'(-(sy >>> 4));
        th = '{8'(6 - ox), 8'(-6 - ox), 8'(6 - oy), 8'(-6 - oy)};
        for (int k = 0; k < 4; k++)
            acc(1, 8'(8'h12 + k), th[k], 0);
        for (int k = 0; k < 4; k++)
            acc(0, 8'(8'h12 + k), 0, {8'hff, th[k]});
        sample <= '{8'(-ox), 8'(-oy)};
        acc(1, 8'h0f, 8'h04, 0);
        acc(0, 8'h11, 0, 0);
        repeat (2 * BC + 20) @(posedge clk);
        irq_is(1'b0);
        sample <= '{8'(12 - ox), 8'(-oy)};
        irq_is(1'b1);
        // Mid-run pin reset must drop the pending interrupt
        host.pin(1'b0);
        repeat (3) @(posedge clk);
        host.pin(1'b1);
        irq_is(1'b0);
        acc(1, 8'h0f, 8'h84, 0);
        acc(0, 8'h0f, 0, 16'hfe84);
        repeat (20) @(posedge clk);
        acc(0, 8'h11, 0, 0);
        repeat (2 * BC + 20) @(posedge clk);
        irq_is(1'b0);
        addr_sel <= 1'b1;
        acc(0, 8'h15, 0, {8'hff, JSB_RST_ZERO});
        repeat (2) @(posedge clk);
        stop_test();
    end
endmodule : tb_joystick_sensor_bringup
